// ---- hdl/ochf_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ochf_top
  import ochf_pkg::*;
#(
  parameter int PERIOD_CYC = PWM_PERIOD_CYC,
  parameter logic [1:0] VARIANT = VARIANT_SOURCE_ONLY
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [9:0] duty_demand,
  input wire logic switch_node_high,
  input wire logic switch_node_low,
  input wire logic current_limit_trip,
  input wire logic zero_current_trip,
  input wire logic ss_below_shutdown,
  input wire logic ss_discharged,
  input wire logic ss_at_700mv,
  input wire logic ss_above_reference,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic softstart_discharge,
  output logic fault_active,
  output logic [2:0] oc_count
);
  localparam int DUTY_LIM = (PERIOD_CYC * DUTY_MAX_PCT) / 100;
  initial begin
    if (PERIOD_CYC < 64 || PERIOD_CYC > 1023) $error("PERIOD_CYC out of range");
    if (VARIANT > VARIANT_GENERAL) $error("bad VARIANT");
  end
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] pins_sync;
  logic sw_high, sw_low, oc_trip, zc_trip, softstart_shutdown_node, ss_dis, ss_700, ss_ref;
  ochf_sync #(.WIDTH(8)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({switch_node_high, switch_node_low, current_limit_trip, zero_current_trip,
               ss_below_shutdown, ss_discharged, ss_at_700mv, ss_above_reference}),
    .sync_out(pins_sync)
  );
  assign {sw_high, sw_low, oc_trip, zc_trip, softstart_shutdown_node, ss_dis, ss_700, ss_ref} = pins_sync;
  // ----------------------------------------
  // PWM timebase
  // ----------------------------------------
  logic [9:0] phase;
  wire cycle_start = (phase == 10'h000);
  wire cycle_end = (phase == 10'(PERIOD_CYC - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) phase <= 10'h000;
    else phase <= cycle_end ? 10'h000 : phase + 10'h001;
  end
  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  ochf_state_type state, next_state;
  logic [2:0] next_count;
  logic oc_seen;
  wire oc_event;
  wire counting = (state == OCHF_RUN);
  wire in_fault = (state == OCHF_FAULT_DISCHARGE) || (state == OCHF_FAULT_CHARGE);
  wire softstart = (state == OCHF_SOFTSTART);
  always_comb begin
    next_state = state;
    next_count = oc_count;
    unique case (state)
      OCHF_SHUTDOWN: begin
        next_count = OC_COUNT_MIN;
        if (!softstart_shutdown_node) next_state = OCHF_SOFTSTART;
      end
      OCHF_SOFTSTART: begin
        if (ss_ref) next_state = OCHF_RUN;
      end
      OCHF_RUN: begin
        if (oc_event && oc_count != OC_COUNT_MAX) next_count = oc_count + 3'h1;
        else if (cycle_end && !oc_seen && !oc_event && oc_count != OC_COUNT_MIN)
          next_count = oc_count - 3'h1;
        if (next_count == OC_COUNT_MAX) next_state = OCHF_FAULT_DISCHARGE;
      end
      OCHF_FAULT_DISCHARGE: begin
        if (oc_count == OC_COUNT_MAX) next_count = OC_COUNT_MAX - 3'h1;
        else if (ss_dis) begin
          next_state = (oc_count == OC_COUNT_MIN) ? OCHF_SOFTSTART : OCHF_FAULT_CHARGE;
        end
      end
      OCHF_FAULT_CHARGE: begin
        // recharge to 700 mV, discharge again
        if (ss_700 && !ss_dis) begin
          next_state = OCHF_FAULT_DISCHARGE;
          next_count = oc_count - 3'h1;
        end
      end
      default: next_state = OCHF_SHUTDOWN;
    endcase
    // shutdown threshold overrides
    // Fault drains the node itself, so its low level is no shutdown here
    // Limitation: an outside pull during fault holds the charge phase
    if (softstart_shutdown_node && !in_fault) next_state = OCHF_SHUTDOWN;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= OCHF_SHUTDOWN;
      oc_count <= OC_COUNT_MIN;
    end else begin
      state <= next_state;
      oc_count <= next_count;
    end
  end
  assign fault_active = in_fault;
  assign softstart_discharge = (state == OCHF_FAULT_DISCHARGE);
  // ----------------------------------------
  // High-side pulse and blanking
  // ----------------------------------------
  logic hs_on, ls_on, hs_done, zc_cut;
  logic [4:0] oc_blank;
  logic [4:0] zc_blank;
  logic [7:0] dead_hl, dead_lh, dead_cnt, meas;
  wire switching = softstart || counting;
  wire oc_armed = hs_on && sw_high && (oc_blank == 5'(OC_BLANK_CYC));
  // arm after switch high and blanking
  assign oc_event = oc_armed && oc_trip;
  wire duty_limit = (phase >= 10'(DUTY_LIM)) || (phase >= duty_demand);
  wire dead_ok = (dead_cnt == 8'h00);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oc_blank <= 5'h00;
    end else if (!hs_on || !sw_high) begin
      oc_blank <= 5'h00;
    end else if (oc_blank != 5'(OC_BLANK_CYC)) begin
      oc_blank <= oc_blank + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hs_on <= 1'b0;
      hs_done <= 1'b0;
      oc_seen <= 1'b0;
    end else begin
      if (cycle_end) hs_done <= 1'b0;
      else if (hs_on && (oc_event || duty_limit)) hs_done <= 1'b1;
      if (cycle_end) oc_seen <= 1'b0;
      else if (oc_event) oc_seen <= 1'b1;
      if (!switching || oc_event || duty_limit || cycle_end) hs_on <= 1'b0;
      else if (!hs_done && !ls_on && dead_ok && !cycle_start) hs_on <= 1'b1;
    end
  end
  // ----------------------------------------
  // Low-side rectifier and zero-current cutoff
  // ----------------------------------------
  // prebias cutoff in softstart
  wire zc_enable = (VARIANT == VARIANT_SOURCE_ONLY) || (VARIANT == VARIANT_PREBIAS && softstart);
  wire zc_armed = ls_on && (zc_blank == 5'(ZC_BLANK_CYC));
  wire zc_event = zc_enable && zc_armed && zc_trip;
  wire ls_want = switching && hs_done && !zc_cut && !cycle_end;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) zc_blank <= 5'h00;
    else if (!ls_on) zc_blank <= 5'h00;
    else if (zc_blank != 5'(ZC_BLANK_CYC)) zc_blank <= zc_blank + 5'h01;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ls_on <= 1'b0;
      zc_cut <= 1'b0;
    end else begin
      if (cycle_end) zc_cut <= 1'b0;
      else if (zc_event) zc_cut <= 1'b1;
      if (!ls_want || zc_event) ls_on <= 1'b0;
      else if (!hs_on && dead_ok) ls_on <= 1'b1;
    end
  end
  // ----------------------------------------
  // Predictive dead time
  // ----------------------------------------
  // Gate-to-node delay of this cycle sets the next cycle's dead time
  // Timing from the low-side fall would include the dead time and grow
  logic hs_prev, ls_prev, meas_hl, meas_lh;
  wire hs_fall = hs_prev && !hs_on;
  wire hs_rise = !hs_prev && hs_on;
  wire ls_fall = ls_prev && !ls_on;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hs_prev <= 1'b0;
      ls_prev <= 1'b0;
      meas_hl <= 1'b0;
      meas_lh <= 1'b0;
      meas <= 8'h00;
      dead_cnt <= 8'h00;
      dead_hl <= 8'(DEAD_DEFAULT_CYC);
      dead_lh <= 8'(DEAD_DEFAULT_CYC);
    end else begin
      hs_prev <= hs_on;
      ls_prev <= ls_on;
      if (hs_fall) dead_cnt <= dead_hl;
      else if (ls_fall) dead_cnt <= dead_lh;
      else if (!dead_ok) dead_cnt <= dead_cnt - 8'h01;
      if (hs_fall || hs_rise) begin
        meas <= 8'h00;
        meas_hl <= hs_fall;
        meas_lh <= hs_rise;
      end else if (meas != 8'hFF) begin
        meas <= meas + 8'h01;
      end
      if (meas_hl && sw_low) begin
        dead_hl <= (meas < 8'(DEAD_MIN_CYC)) ? 8'(DEAD_MIN_CYC) : meas;
        meas_hl <= 1'b0;
      end
      if (meas_lh && !sw_low) begin
        dead_lh <= (meas < 8'(DEAD_MIN_CYC)) ? 8'(DEAD_MIN_CYC) : meas;
        meas_lh <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Gate outputs
  // ----------------------------------------
  // fault forces low side on
  assign high_side_gate_drive = hs_on && switching;
  assign low_side_gate_drive = in_fault || (ls_on && switching);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_fault_entry;
    counting && next_count == OC_COUNT_MAX && !softstart_shutdown_node;
  endsequence
  chk_shutdown_gates_low: assert property (@(posedge clk_sys) disable iff (rst)
    state == OCHF_SHUTDOWN |-> !high_side_gate_drive && !low_side_gate_drive)
    else $error("gate driven in shutdown");
  chk_shutdown_entry: assert property (@(posedge clk_sys) disable iff (rst)
    softstart_shutdown_node && !in_fault |=> state == OCHF_SHUTDOWN) else $error("no shutdown");
  chk_fault_entry: assert property (@(posedge clk_sys) disable iff (rst)
    s_fault_entry |=> fault_active && low_side_gate_drive && !high_side_gate_drive)
    else $error("fault not entered");
  chk_oc_ends_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    oc_event |=> !hs_on) else $error("pulse not ended");
  chk_count_sat_top: assert property (@(posedge clk_sys) disable iff (rst)
    $past(oc_count) == OC_COUNT_MAX |-> oc_count != OC_COUNT_MIN)
    else $error("counter wrapped");
  chk_soft_nocount: assert property (@(posedge clk_sys) disable iff (rst)
    softstart && $past(softstart) |-> $stable(oc_count)) else $error("counted in softstart");
  chk_duty_limit: assert property (@(posedge clk_sys) disable iff (rst)
    high_side_gate_drive |-> phase <= 10'(DUTY_LIM)) else $error("duty over limit");
  chk_zc_blanking: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ls_on) |-> !zc_event [*2]) else $error("zero current not blanked");
  chk_general_nocut: assert property (@(posedge clk_sys) disable iff (rst)
    VARIANT == VARIANT_GENERAL |-> !zc_cut) else $error("cutoff in general variant");
  chk_fault_restart: assert property (@(posedge clk_sys) disable iff (rst)
    state == OCHF_FAULT_DISCHARGE && ss_dis && oc_count == OC_COUNT_MIN
    |=> state == OCHF_SOFTSTART) else $error("no restart");
endmodule // ochf_top
`default_nettype wire

// ---- include/ochf_pkg.sv ----
`default_nettype none
package ochf_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OC_BLANK_NS = 100;
  localparam int OC_BLANK_CYC = (OC_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ZC_BLANK_NS = 75;
  localparam int ZC_BLANK_CYC = (ZC_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWM_PERIOD_CYC = 833;
  localparam int DUTY_MAX_PCT = 95;
  localparam int DUTY_MAX_CYC = (PWM_PERIOD_CYC * DUTY_MAX_PCT) / 100;
  localparam int DEAD_DEFAULT_CYC = 8;
  localparam int DEAD_MIN_CYC = 1;
  // ----------------------------------------
  // Counter and variants
  // ----------------------------------------
  localparam logic [2:0] OC_COUNT_MAX = 3'h7;
  localparam logic [2:0] OC_COUNT_MIN = 3'h0;
  localparam logic [1:0] VARIANT_SOURCE_ONLY = 2'h0;
  localparam logic [1:0] VARIANT_PREBIAS = 2'h1;
  localparam logic [1:0] VARIANT_GENERAL = 2'h2;
  typedef enum logic [2:0] {OCHF_SHUTDOWN, OCHF_SOFTSTART, OCHF_RUN, OCHF_FAULT_DISCHARGE,
                            OCHF_FAULT_CHARGE} ochf_state_type;
endpackage
`default_nettype wire

// ---- hdl/ochf_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ochf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // ochf_sync
`default_nettype wire

// ---- sim/ochf_bridge_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ochf_bridge_model (
  input wire logic clk_sys,
  input wire logic hs,
  input wire logic dis,
  input wire logic overload,
  input wire logic light_load,
  input wire logic sd_pull,
  output logic sw_hi,
  output logic sw_lo,
  output logic oc_trip,
  output logic zc_trip,
  output logic softstart_shutdown_node,
  output logic ss_dis,
  output logic ss_700,
  output logic ss_ref
);
  // ----------------------------------------
  // Half-bridge and soft-start capacitor
  // ----------------------------------------
  // Node lags the gate by two cycles of slew
  logic [1:0] hs_d = 2'h0;
  // Cap level in 1.25 mV steps, fast discharge
  int lvl = 0;
  always @(posedge clk_sys) begin
    hs_d <= {hs_d[0], hs};
    if (sd_pull) lvl <= 0;
    else if (dis) lvl <= (lvl > 16) ? lvl - 16 : 0;
    else if (lvl < 1200) lvl <= lvl + 1;
  end
  assign sw_hi = hs_d[1];
  assign sw_lo = ~hs_d[1];
  assign oc_trip = overload & hs_d[1];
  assign zc_trip = light_load & ~hs_d[1];
  assign softstart_shutdown_node = lvl < 96;
  assign ss_dis = lvl == 0;
  assign ss_700 = lvl >= 560;
  assign ss_ref = lvl >= 560;
endmodule // ochf_bridge_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ochf_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  localparam int PER = 100;
  localparam int LIM = (PER * DUTY_MAX_PCT) / 100;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic overload = 1'b0;
  logic light_load = 1'b0;
  logic sd_pull = 1'b1;
  logic [9:0] duty_demand = 10'h03C;
  logic sw_hi, sw_lo, oc_trip, zc_trip, softstart_shutdown_node, ss_dis, ss_700, ss_ref;
  logic hs, ls, dis, fault;
  logic [2:0] oc_count;
  int fail_count = 0;
  int n_checks = 0;
  int hs_n, ls_n;
  logic both_on;
  logic ls_gen, ls_pre;
  int ls_gen_n, ls_pre_n;

  ochf_top #(.PERIOD_CYC(PER), .VARIANT(VARIANT_SOURCE_ONLY)) dut (
    .clk_sys(clk_sys), .rst(rst), .duty_demand(duty_demand), .switch_node_high(sw_hi),
    .switch_node_low(sw_lo), .current_limit_trip(oc_trip), .zero_current_trip(zc_trip),
    .ss_below_shutdown(softstart_shutdown_node), .ss_discharged(ss_dis), .ss_at_700mv(ss_700),
    .ss_above_reference(ss_ref), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .softstart_discharge(dis), .fault_active(fault), .oc_count(oc_count));

  // Same stimulus, other variants: only their low-side gates are judged
  ochf_top #(.PERIOD_CYC(PER), .VARIANT(VARIANT_GENERAL)) dut_gen (
    .clk_sys(clk_sys), .rst(rst), .duty_demand(duty_demand), .switch_node_high(sw_hi),
    .switch_node_low(sw_lo), .current_limit_trip(oc_trip), .zero_current_trip(zc_trip),
    .ss_below_shutdown(softstart_shutdown_node), .ss_discharged(ss_dis), .ss_at_700mv(ss_700),
    .ss_above_reference(ss_ref), .high_side_gate_drive(), .low_side_gate_drive(ls_gen),
    .softstart_discharge(), .fault_active(), .oc_count());

  ochf_top #(.PERIOD_CYC(PER), .VARIANT(VARIANT_PREBIAS)) dut_pre (
    .clk_sys(clk_sys), .rst(rst), .duty_demand(duty_demand), .switch_node_high(sw_hi),
    .switch_node_low(sw_lo), .current_limit_trip(oc_trip), .zero_current_trip(zc_trip),
    .ss_below_shutdown(softstart_shutdown_node), .ss_discharged(ss_dis), .ss_at_700mv(ss_700),
    .ss_above_reference(ss_ref), .high_side_gate_drive(), .low_side_gate_drive(ls_pre),
    .softstart_discharge(), .fault_active(), .oc_count());

  ochf_bridge_model bridge (
    .clk_sys(clk_sys), .hs(hs), .dis(dis), .overload(overload), .light_load(light_load),
    .sd_pull(sd_pull), .sw_hi(sw_hi), .sw_lo(sw_lo), .oc_trip(oc_trip), .zc_trip(zc_trip),
    .softstart_shutdown_node(softstart_shutdown_node), .ss_dis(ss_dis), .ss_700(ss_700), .ss_ref(ss_ref));

  initial forever #2 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic cond(input int sel, input logic [2:0] v);
    case (sel)
      0: return oc_count === v;
      1: return hs === v[0];
      2: return ss_ref === 1'b1;
      default: return fault === v[0];
    endcase
  endfunction

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_for(input int sel, input logic [2:0] v, input int bound);
    int i;
    for (i = 0; i < bound && !cond(sel, v); i++) tick(1);
    if (i == bound) begin
      fail_count++;
      finish_test();
    end
  endtask

  // One period from a high-side rise: pulse width and rectifier time
  task automatic run_period();
    logic on;
    wait_for(1, 3'h0, 2 * PER);
    wait_for(1, 3'h1, 3 * PER);
    hs_n = 0;
    ls_n = 0;
    ls_gen_n = 0;
    ls_pre_n = 0;
    both_on = 1'b0;
    on = 1'b1;
    repeat (PER) begin
      on &= (hs === 1'b1);
      hs_n += on;
      ls_n += (ls === 1'b1);
      ls_gen_n += (ls_gen === 1'b1);
      ls_pre_n += (ls_pre === 1'b1);
      both_on |= (hs === 1'b1) && (ls === 1'b1);
      tick(1);
    end
    check(both_on, 0);
  endtask

  task automatic t_shutdown();
    tick(12);
    check({hs, ls, oc_count}, 5'h00);
  endtask

  task automatic t_softstart();
    sd_pull = 1'b0;
    overload = 1'b1;
    run_period();
    check(hs_n >= OC_BLANK_CYC && hs_n < 45, 1);
    check(oc_count, 3'h0);
  endtask

  task automatic t_fault();
    int rises, bad, steps;
    logic pd;
    logic [2:0] pc;
    wait_for(2, 3'h1, 1000);
    wait_for(0, 3'h7, 10 * PER);
    wait_for(3, 3'h1, 10);
    check({hs, ls}, 2'h1);
    rises = 0;
    bad = 0;
    pd = 1'b0;
    pc = oc_count;
    for (steps = 0; steps < 8000 && fault === 1'b1; steps++) begin
      rises += (dis === 1'b1 && pd === 1'b0);
      bad += ({hs, ls} !== 2'h1) || (oc_count !== pc && oc_count !== pc - 3'h1);
      pd = dis;
      pc = oc_count;
      tick(1);
    end
    check(bad, 0);
    check(rises, 7);
    check({fault, oc_count}, 4'h0);
    run_period();
    check(oc_count, 3'h0);
  endtask

  task automatic t_counting();
    wait_for(2, 3'h1, 1000);
    wait_for(0, 3'h3, 6 * PER);
    overload = 1'b0;
    wait_for(0, 3'h2, 2 * PER);
    wait_for(0, 3'h1, PER + 10);
    wait_for(0, 3'h0, PER + 10);
    tick(3 * PER);
    check(oc_count, 3'h0);
  endtask

  task automatic t_duty();
    duty_demand = 10'h3FF;
    run_period();
    check(hs_n <= LIM && hs_n >= LIM - 12, 1);
  endtask

  // Cut must not latch past the period it happened in
  task automatic t_zero();
    duty_demand = 10'h01E;
    light_load = 1'b1;
    repeat (2) begin
      run_period();
      check(ls_n >= ZC_BLANK_CYC && ls_n < ZC_BLANK_CYC + 8, 1);
      check(ls_gen_n > 40, 1);
      check(ls_pre_n > 40, 1);
    end
    light_load = 1'b0;
    run_period();
    check(ls_n > 40, 1);
  endtask

  initial begin
    tick(5);
    rst = 1'b0;
    t_shutdown();
    t_softstart();
    t_fault();
    t_counting();
    t_duty();
    t_zero();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
